// File: etb_top.sv
// execution trace buffer: branch packet capture into shared sram
`timescale 1ns/1ps
// Summary of operation
// - trace sram writes beat processor accesses
// - non-sequential pc change stores two-word packet
// - branches and exception entry both traced
// - record only while enable bit is one
// - software enable write starts or stops tracing
// - auto-stop at threshold pointer clears enable
// - without threshold, pointer wraps, overwrites oldest
// - registers at fixed base and offsets
// - position, master, flow, base registers
// - base register reports sram location
// - software sets buffer start and size
// - processor keeps general sram access
module etb_top
    import etb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_exec_valid,
    input wire logic [31:0] i_exec_pc,
    input wire logic i_exec_long,
    input wire logic i_exec_exc,
    output logic o_exec_ready,
    input wire logic i_cpu_req,
    input wire logic i_cpu_we,
    input wire logic [ETB_AW-1:0] i_cpu_addr,
    input wire logic [31:0] i_cpu_wdata,
    output logic o_cpu_ack,
    output logic [31:0] o_cpu_rdata,
    input wire logic i_reg_wr,
    input wire logic [3:0] i_reg_offs,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_position,
    output logic [31:0] o_master,
    output logic [31:0] o_flow,
    output logic [31:0] o_base,
    output logic o_halt_req
);
    // buffer size in packets minus one, from the size code
    function automatic logic [6:0] size_mask(input logic [4:0] code);
        logic [7:0] t;
        t = (8'h01 << (code + 5'h01)) - 8'h01;
        size_mask = (code >= ETB_SIZE_FULL) ? 7'h7F : t[6:0];
    endfunction : size_mask

    etb_state_e st_q, st_d;
    logic [31:0] pos_q, pos_d, mst_q, mst_d, flw_q, flw_d, base_q;
    logic [63:0] e0_q, e0_d, e1_q, e1_d, pkt;
    logic [31:0] hold_q, hold_d, prev_pc_q, prev_pc_d, prev_len_q, prev_len_d;
    logic [1:0] cnt_q, cnt_d;
    logic rdy_q, rdy_d, prev_vld_q, prev_vld_d, start_q, start_d;
    logic ack_q, ack_d, halt_q, halt_d;
    logic take, nonseq, push, pop, trace_busy, cpu_go, wr_pos, wr_mst, wr_flw;
    logic mem_we, mem_re, wrapped, at_mark;
    logic [ETB_AW-1:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [6:0] ptr, msk, inc, nptr;

    // register write decode at fixed offsets
    assign wr_pos = i_reg_wr && (i_reg_offs == ETB_OFF_POSITION);
    assign wr_mst = i_reg_wr && (i_reg_offs == ETB_OFF_MASTER);
    assign wr_flw = i_reg_wr && (i_reg_offs == ETB_OFF_FLOW);

    // non-sequential detection and packet build
    assign take = i_exec_valid && rdy_q;
    assign nonseq = i_exec_exc || (prev_vld_q
        && (i_exec_pc != prev_pc_q + prev_len_q));
    assign push = take && nonseq && prev_vld_q && mst_q[ETB_EN_BIT];
    assign pkt = {prev_pc_q[31:1], i_exec_exc,
        i_exec_pc[31:1], start_q};
    assign pop = (st_q == ETB_ST_IDLE) && (cnt_q != 2'h0);

    // pointer advance inside the software-sized window
    assign ptr = pos_q[ETB_PTR_MSB:ETB_PTR_LSB];
    assign msk = size_mask(mst_q[ETB_SIZE_MSB:0]);
    assign inc = ptr + 7'h01;
    assign nptr = (ptr & ~msk) | (inc & msk);
    assign wrapped = (inc & msk) == 7'h00;
    assign at_mark = flw_q[ETB_STOP_BIT]
        && (nptr == flw_q[ETB_PTR_MSB:ETB_PTR_LSB]);

    // sram arbitration: trace writes first, processor waits
    assign trace_busy = pop || (st_q == ETB_ST_HI);
    assign cpu_go = i_cpu_req && !ack_q && !trace_busy;
    assign mem_we = trace_busy || (cpu_go && i_cpu_we);
    assign mem_re = cpu_go && !i_cpu_we;
    assign mem_addr = pop ? {ptr, 1'b0} :
        (st_q == ETB_ST_HI) ? {ptr, 1'b1} : i_cpu_addr;
    assign mem_wdata = pop ? e0_q[63:32] :
        (st_q == ETB_ST_HI) ? hold_q : i_cpu_wdata;

    // next-state for buffer, writer, registers and handshakes
    always_comb begin
        st_d = st_q;
        e0_d = e0_q;
        e1_d = e1_q;
        hold_d = hold_q;
        cnt_d = cnt_q;
        pos_d = pos_q;
        mst_d = mst_q;
        flw_d = flw_q;
        halt_d = halt_q;
        start_d = start_q;
        prev_pc_d = prev_pc_q;
        prev_len_d = prev_len_q;
        prev_vld_d = prev_vld_q;
        ack_d = cpu_go;
        if (take) begin
            prev_pc_d = i_exec_pc;
            prev_len_d = i_exec_long ? ETB_LEN_LONG : ETB_LEN_SHORT;
            prev_vld_d = 1'b1;
        end
        // two-entry buffer, head in e0
        if (pop) begin
            e0_d = e1_q;
            hold_d = e0_q[31:0];
        end
        if (push) begin
            if ((cnt_q == 2'h0) || ((cnt_q == 2'h1) && pop)) begin
                e0_d = pkt;
            end else begin
                e1_d = pkt;
            end
            start_d = 1'b0;
        end
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
        rdy_d = (cnt_d != ETB_FIFO_FULL);
        // packet writer: low word on pop, high word next cycle
        case (st_q)
            ETB_ST_IDLE: begin
                if (pop) begin
                    st_d = ETB_ST_HI;
                end
            end
            ETB_ST_HI: begin
                st_d = ETB_ST_IDLE;
                pos_d[ETB_PTR_MSB:ETB_PTR_LSB] = nptr;
                if (wrapped) begin
                    pos_d[ETB_WRAP_BIT] = 1'b1;
                end
                if (at_mark) begin
                    mst_d[ETB_EN_BIT] = 1'b0;
                end
            end
            default: st_d = ETB_ST_IDLE;
        endcase
        // software writes; a hardware wrap or stall in the same cycle wins
        if (wr_pos) begin
            pos_d = (i_reg_wdata & ETB_POS_WMASK)
                | {29'h0, (st_q == ETB_ST_HI) && wrapped,
                2'h0};
        end
        if (wr_mst) begin
            mst_d = i_reg_wdata & ETB_MASTER_WMASK;
            halt_d = 1'b0;
            if (i_reg_wdata[ETB_EN_BIT] && !mst_q[ETB_EN_BIT]) begin
                start_d = 1'b1;
            end
        end
        if (wr_flw) begin
            flw_d = i_reg_wdata & ETB_FLOW_WMASK;
            halt_d = 1'b0;
        end
        if ((st_q == ETB_ST_HI) && at_mark && flw_q[ETB_STALL_BIT]) begin
            halt_d = 1'b1;
        end
    end

    // state registers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= ETB_ST_IDLE;
            e0_q <= {ETB_RST_WORD, ETB_RST_WORD};
            e1_q <= {ETB_RST_WORD, ETB_RST_WORD};
            hold_q <= ETB_RST_WORD;
            cnt_q <= 2'h0;
            rdy_q <= 1'b0;
            pos_q <= ETB_RST_WORD;
            mst_q <= ETB_RST_WORD;
            flw_q <= ETB_RST_WORD;
            base_q <= ETB_SRAM_BASE;
            halt_q <= 1'b0;
            start_q <= 1'b0;
            prev_pc_q <= ETB_RST_WORD;
            prev_len_q <= ETB_RST_WORD;
            prev_vld_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            st_q <= st_d;
            e0_q <= e0_d;
            e1_q <= e1_d;
            hold_q <= hold_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            pos_q <= pos_d;
            mst_q <= mst_d;
            flw_q <= flw_d;
            halt_q <= halt_d;
            start_q <= start_d;
            prev_pc_q <= prev_pc_d;
            prev_len_q <= prev_len_d;
            prev_vld_q <= prev_vld_d;
            ack_q <= ack_d;
        end
    end

    // shared sram, used by trace writes and processor accesses
    etb_sram u_sram (
        .i_clk(i_clk),
        .i_we(mem_we),
        .i_re(mem_re),
        .i_addr(mem_addr),
        .i_wdata(mem_wdata),
        .o_rdata(o_cpu_rdata)
    );

    // outputs straight from registers
    assign o_exec_ready = rdy_q;
    assign o_cpu_ack = ack_q;
    assign o_position = pos_q;
    assign o_master = mst_q;
    assign o_flow = flw_q;
    assign o_base = base_q;
    assign o_halt_req = halt_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    property p_trace_first;
        trace_busy |=> !o_cpu_ack;
    endproperty
    a_trace_first: assert property (p_trace_first)
        else $error("processor acked while trace owned sram");

    property p_two_words;
        pop |-> mem_we ##1 (st_q == ETB_ST_HI && mem_we) ##1
            (st_q == ETB_ST_IDLE);
    endproperty
    a_two_words: assert property (p_two_words)
        else $error("packet not written as two words");

    property p_exc_traced;
        (take && i_exec_exc && prev_vld_q && mst_q[ETB_EN_BIT])
            |=> (cnt_q != 2'h0);
    endproperty
    a_exc_traced: assert property (p_exc_traced)
        else $error("exception entry not queued");

    property p_off_quiet;
        !mst_q[ETB_EN_BIT] |=> (cnt_q <= $past(cnt_q));
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("packet queued while disabled");

    property p_sw_enable;
        wr_mst |=> (mst_q[ETB_EN_BIT] == $past(i_reg_wdata[ETB_EN_BIT]));
    endproperty
    a_sw_enable: assert property (p_sw_enable)
        else $error("enable bit does not follow software write");

    property p_halt_trace_at_threshold;
        (st_q == ETB_ST_HI && at_mark && !wr_mst) |=> !mst_q[ETB_EN_BIT];
    endproperty
    a_halt_trace_at_threshold: assert property (p_halt_trace_at_threshold)
        else $error("tracing not stopped at threshold");

    property p_wrap;
        (st_q == ETB_ST_HI && wrapped && !wr_pos) |=>
            pos_q[ETB_WRAP_BIT] && (ptr == ($past(ptr) & ~$past(msk)));
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("pointer did not wrap to buffer start");

    property p_advance;
        (st_q == ETB_ST_HI && !wr_pos) |=> (ptr == $past(nptr));
    endproperty
    a_advance: assert property (p_advance)
        else $error("pointer not advanced by one packet");

    property p_cpu_served;
        (i_cpu_req && !ack_q && st_q == ETB_ST_IDLE && cnt_q == 2'h0)
            |=> o_cpu_ack;
    endproperty
    a_cpu_served: assert property (p_cpu_served)
        else $error("idle sram did not serve processor");
endmodule : etb_top

// File: etb_pkg.sv
// shared constants for the execution trace buffer
package etb_pkg;
    // register map seen by software
    localparam logic [31:0] ETB_REG_BASE = 32'h4100_6000;
    localparam logic [3:0] ETB_OFF_POSITION = 4'h0;
    localparam logic [3:0] ETB_OFF_MASTER = 4'h4;
    localparam logic [3:0] ETB_OFF_FLOW = 4'h8;
    localparam logic [3:0] ETB_OFF_BASE = 4'hC;
    // sram geometry: 256 words of 32 bits
    localparam int ETB_AW = 8;
    localparam int ETB_DEPTH = 256;
    localparam logic [31:0] ETB_SRAM_BASE = 32'h2000_0000;
    // position fields: pointer in bits 9..3, wrap flag in bit 2
    localparam int ETB_PTR_LSB = 3;
    localparam int ETB_PTR_MSB = 9;
    localparam int ETB_WRAP_BIT = 2;
    localparam logic [31:0] ETB_POS_WMASK = 32'h0000_03FC;
    // master fields: enable in bit 31, buffer size code in bits 4..0
    localparam int ETB_EN_BIT = 31;
    localparam int ETB_SIZE_MSB = 4;
    localparam logic [31:0] ETB_MASTER_WMASK = 32'h8000_001F;
    // flow fields: threshold in bits 9..3, stall bit 1, stop bit 0
    localparam int ETB_STALL_BIT = 1;
    localparam int ETB_STOP_BIT = 0;
    localparam logic [31:0] ETB_FLOW_WMASK = 32'h0000_03FB;
    localparam logic [31:0] ETB_RST_WORD = 32'h0000_0000;
    // instruction lengths in bytes
    localparam logic [31:0] ETB_LEN_SHORT = 32'h0000_0002;
    localparam logic [31:0] ETB_LEN_LONG = 32'h0000_0004;
    // size codes at or above this cover the whole sram
    localparam logic [4:0] ETB_SIZE_FULL = 5'h06;
    localparam logic [1:0] ETB_FIFO_FULL = 2'h2;
    // packet writer states
    typedef enum logic [1:0] {
        ETB_ST_IDLE = 2'b01,
        ETB_ST_HI = 2'b10
    } etb_state_e;
endpackage : etb_pkg

// File: etb_sram.sv
// single-port word memory shared by trace writes and the processor
`timescale 1ns/1ps
module etb_sram
    import etb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic i_re,
    input wire logic [ETB_AW-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_rdata
);
    logic [31:0] mem [ETB_DEPTH];

    // write port and registered read data
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        if (i_re) begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule : etb_sram

// File: etb_exec_model.sv
// behavioural processor model feeding the execution trace port
`timescale 1ns/1ps
module etb_exec_model (
    input wire logic i_clk,
    input wire logic i_ready,
    output logic o_valid,
    output logic [31:0] o_pc,
    output logic o_long,
    output logic o_exc
);
    logic [33:0] pend_q[$];
    int gap = 0;
    int idle_n = 0;
    // start quiet so the port sees no request before reset ends
    initial begin
        o_valid = 1'b0;
        o_pc = 32'h0000_0000;
        o_long = 1'b0;
        o_exc = 1'b0;
    end
    // queue one retired instruction
    task push(input logic [31:0] pc, input logic lng, input logic exc);
        pend_q.push_back({pc, lng, exc});
    endtask : push
    // hold until taken; idle pc and exc lines scramble so stale values never match
    always @(posedge i_clk) begin
        if (!o_valid || i_ready) begin
            if (pend_q.size() > 0 && idle_n >= gap) begin
                {o_pc, o_long, o_exc} <= pend_q.pop_front();
                o_valid <= 1'b1;
                idle_n <= 0;
            end else begin
                o_valid <= 1'b0;
                o_pc <= ~o_pc;
                o_exc <= ~o_exc;
                idle_n <= idle_n + 1;
            end
        end
    end
endmodule : etb_exec_model

// File: testbench.sv
// self-checking bench for the execution trace buffer
`timescale 1ns/1ps
`define ETB_CHK(nm, ex, got) begin \
    total_checks++; \
    if ((got) !== (ex)) begin \
        err_total++; \
        $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
end
module testbench;
    import etb_pkg::*;
    logic i_clk, i_nrst, i_cpu_req, i_cpu_we, i_reg_wr;
    logic [ETB_AW-1:0] i_cpu_addr;
    logic [31:0] i_cpu_wdata, i_reg_wdata, rd_exp, rnd;
    logic [3:0] i_reg_offs;
    logic ex_valid, ex_long, ex_exc, o_exec_ready, o_cpu_ack, o_halt_req;
    logic [31:0] ex_pc, o_cpu_rdata, o_position, o_master, o_flow, o_base;
    logic [31:0] exp_q[$];
    int err_total = 0;
    int total_checks = 0;
    int seed = 52612;
    etb_top DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_exec_valid(ex_valid),
        .i_exec_pc(ex_pc), .i_exec_long(ex_long), .i_exec_exc(ex_exc),
        .o_exec_ready(o_exec_ready), .i_cpu_req(i_cpu_req),
        .i_cpu_we(i_cpu_we), .i_cpu_addr(i_cpu_addr),
        .i_cpu_wdata(i_cpu_wdata), .o_cpu_ack(o_cpu_ack),
        .o_cpu_rdata(o_cpu_rdata), .i_reg_wr(i_reg_wr),
        .i_reg_offs(i_reg_offs), .i_reg_wdata(i_reg_wdata),
        .o_position(o_position), .o_master(o_master), .o_flow(o_flow),
        .o_base(o_base), .o_halt_req(o_halt_req));
    etb_exec_model PM (.i_clk(i_clk), .i_ready(o_exec_ready),
        .o_valid(ex_valid), .o_pc(ex_pc), .o_long(ex_long), .o_exc(ex_exc));
    // free-running system clock
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // print counts and verdict, then stop
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    // one register write strobe, outputs settled on return
    task wreg(input logic [3:0] offs, input logic [31:0] data);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_offs <= offs;
        i_reg_wdata <= data;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        #1;
    endtask : wreg
    // sram access held until ack; a read notes its expected word
    task sram(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_clk);
        i_cpu_req <= 1'b1;
        i_cpu_we <= we;
        i_cpu_addr <= a;
        i_cpu_wdata <= d;
        if (!we) exp_q.push_back(d);
        do begin
            @(posedge i_clk);
            k++;
        end while (o_cpu_ack !== 1'b1 && k < 100);
        if (o_cpu_ack !== 1'b1) err_total++;
        i_cpu_req <= 1'b0;
    endtask : sram
    // wait for the processor model to empty, then let writes land
    task drain;
        int k;
        k = 0;
        while ((PM.pend_q.size() != 0 || PM.o_valid) && k < 300) begin
            @(posedge i_clk);
            k++;
        end
        if (PM.pend_q.size() != 0 || PM.o_valid) err_total++;
        repeat (8) @(posedge i_clk);
        #1;
    endtask : drain
    // read data monitor: oldest note against the acked word
    always @(posedge i_clk) begin
        if (o_cpu_ack === 1'b1 && i_cpu_we === 1'b0) begin
            rd_exp = exp_q.pop_front();
            `ETB_CHK("sram read", rd_exp, o_cpu_rdata)
        end
    end
    // hang guard
    initial begin
        repeat (4000) @(posedge i_clk);
        err_total++;
        test_done();
    end
    // main sequence
    initial begin
        i_nrst = 1'b0;
        i_cpu_req = 1'b0;
        i_cpu_we = 1'b0;
        i_cpu_addr = 8'h00;
        i_cpu_wdata = 32'h0;
        i_reg_wr = 1'b0;
        i_reg_offs = 4'h0;
        i_reg_wdata = 32'h0;
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        `ETB_CHK("position", 32'h0, o_position)
        `ETB_CHK("base", ETB_SRAM_BASE, o_base)
        `ETB_CHK("ready", 1'b1, o_exec_ready)
        `ETB_CHK("master", 32'h0, o_master)
        $display("test reset done");
        wreg(ETB_OFF_FLOW, 32'hFFFF_FFFF);
        `ETB_CHK("flow", ETB_FLOW_WMASK, o_flow)
        wreg(ETB_OFF_BASE, 32'h0);
        `ETB_CHK("base", ETB_SRAM_BASE, o_base)
        wreg(ETB_OFF_FLOW, 32'h0);
        $display("test registers done");
        wreg(ETB_OFF_MASTER, 32'h8000_0006);
        PM.push(32'h100, 1'b0, 1'b0);
        PM.push(32'h102, 1'b0, 1'b0);
        PM.push(32'h200, 1'b1, 1'b0);
        PM.push(32'h204, 1'b1, 1'b1);
        PM.push(32'h208, 1'b0, 1'b0);
        rnd = $random(seed);
        sram(1'b1, 8'hC8, rnd);
        sram(1'b0, 8'hC8, rnd);
        drain();
        `ETB_CHK("position", 32'h10, o_position)
        sram(1'b0, 8'h00, 32'h102);
        sram(1'b0, 8'h01, 32'h201);
        sram(1'b0, 8'h02, 32'h201);
        sram(1'b0, 8'h03, 32'h204);
        $display("test trace done");
        wreg(ETB_OFF_MASTER, 32'h0000_0006);
        PM.push(32'h300, 1'b0, 1'b0);
        drain();
        `ETB_CHK("position", 32'h10, o_position)
        $display("test disable done");
        wreg(ETB_OFF_POSITION, 32'h0);
        wreg(ETB_OFF_MASTER, 32'h8000_0000);
        PM.push(32'h400, 1'b0, 1'b0);
        PM.push(32'h500, 1'b0, 1'b0);
        PM.push(32'h600, 1'b0, 1'b0);
        drain();
        `ETB_CHK("position", 32'h0C, o_position)
        sram(1'b0, 8'h00, 32'h500);
        sram(1'b0, 8'h02, 32'h400);
        $display("test wrap done");
        wreg(ETB_OFF_POSITION, 32'h0);
        wreg(ETB_OFF_FLOW, 32'h13);
        wreg(ETB_OFF_MASTER, 32'h8000_0006);
        PM.gap = 10;
        PM.push(32'h700, 1'b0, 1'b0);
        PM.push(32'h800, 1'b0, 1'b0);
        PM.push(32'h900, 1'b0, 1'b0);
        drain();
        `ETB_CHK("master", 32'h6, o_master)
        `ETB_CHK("position", 32'h10, o_position)
        `ETB_CHK("halt", 1'b1, o_halt_req)
        wreg(ETB_OFF_FLOW, 32'h0);
        `ETB_CHK("halt", 1'b0, o_halt_req)
        $display("test auto stop done");
        // second reset in mid-run clears state and refuses instructions
        @(posedge i_clk);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
        `ETB_CHK("ready", 1'b0, o_exec_ready)
        `ETB_CHK("position", 32'h0, o_position)
        `ETB_CHK("base", ETB_SRAM_BASE, o_base)
        @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        `ETB_CHK("ready", 1'b1, o_exec_ready)
        `ETB_CHK("master", 32'h0, o_master)
        $display("test reset again done");
        test_done();
    end
endmodule : testbench
